//--- pkg/sssc_pkg.sv
package sssc_pkg;

    // Clock and array sizes
    localparam int CLK_MHZ = 40;
    localparam int NUM_IN = 24;
    localparam int IDX_W = 5;
    localparam int WC_W = 3;
    localparam int CNT_W = 28;

    // Configuration block covered by the checksum
    localparam logic [7:0] CFG_FIRST_ADDR = 8'h1a;
    localparam logic [7:0] CFG_LAST_ADDR = 8'h24;
    localparam int NUM_CFG = int'(CFG_LAST_ADDR) - int'(CFG_FIRST_ADDR) + 1;
    localparam int CFG_W = 24;
    localparam int CFG_IDX_W = 4;
    localparam int CFG_BIT_W = 5;
    localparam int CRC_TRIG_POS = 1;
    localparam int CRC_CYCLES = NUM_CFG * CFG_W + 1;

    typedef logic [NUM_CFG-1:0][CFG_W-1:0] sssc_cfg_arr_t;

    // Ones mark implemented bits; zeros are reserved and fed as zero
    localparam sssc_cfg_arr_t CFG_USED_MASK = {NUM_CFG{24'hffffff}};

    // Checksum engine
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_SEED = 16'hffff;
    localparam logic [15:0] CRC_XOR = 16'h0000;

    // Wetting current codes
    localparam logic [WC_W-1:0] WC_0MA = 3'h0;
    localparam logic [WC_W-1:0] WC_1MA = 3'h1;
    localparam logic [WC_W-1:0] WC_2MA = 3'h2;
    localparam logic [WC_W-1:0] WC_5MA = 3'h3;
    localparam logic [WC_W-1:0] WC_10MA = 3'h4;
    localparam logic [WC_W-1:0] WC_15MA = 3'h5;

    // Timing
    localparam int ON_BASE_US = 64;
    localparam int PERIOD_BASE_MS = 2;
    localparam int STARTUP_US = 100;
    localparam int ON_FIELD_MAX = 5;
    localparam int PERIOD_FIELD_MAX = 11;
    localparam int DWELL_CYC = 4;
    localparam int ON_BASE_CYC = ON_BASE_US * CLK_MHZ;
    localparam int PERIOD_BASE_CYC = PERIOD_BASE_MS * 1000 * CLK_MHZ;
    localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;

    // Reset values
    localparam logic [NUM_IN-1:0] RST_SWITCH_STATUS = 24'h000000;
    localparam logic [15:0] RST_CRC_RESULT = 16'h0000;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_START = 2'b01,
        S_SCAN = 2'b10,
        S_WAIT = 2'b11
    } sssc_state_t;

    typedef struct packed {
        logic checksum_done_flag;
        logic switch_change_flag;
    } sssc_irq_stat_t;

endpackage

//--- verilog/sssc_crc16.sv
`timescale 1ns/100ps
module sssc_crc16 (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Bit stream
    input wire logic crc_clear,
    input wire logic crc_shift,
    input wire logic crc_din,
    // Result
    output logic [15:0] crc_value
);
    import sssc_pkg::*;

    logic [15:0] crc_reg;
    logic [15:0] crc_next;
    logic feedback;

    // MSB first, no reflection
    always_comb begin
        feedback = crc_reg[15] ^ crc_din;
        crc_next = crc_reg;
        if (crc_clear) begin
            crc_next = CRC_SEED;
        end else if (crc_shift) begin
            crc_next = {crc_reg[14:0], 1'b0} ^ (feedback ? CRC_POLY : 16'h0000);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            crc_reg <= CRC_SEED;
        end else begin
            crc_reg <= crc_next;
        end
    end

    assign crc_value = crc_reg ^ CRC_XOR;

endmodule

//--- verilog/sssc_scan_seq.sv
`timescale 1ns/100ps
// How it works
// RQ1 - Checksum is CRC-16, polynomial 1021h, seed FFFFh, unreflected, no final XOR.
// RQ2 - Checksum covers configuration registers 1Ah through 24h inclusive.
// RQ3 - Reserved configuration bits are fed to the checksum as zero.
// RQ4 - Writing one to the trigger bit starts it; bit clears when done.
// RQ5 - The trigger bit is fed as one during the calculation.
// RQ6 - On completion result is stored, done flag set, interrupt issued; code sets the done flag only when its enable bit is set.
// RQ7 - Done interrupt suppressed when its enable bit is clear.
// RQ8 - Host must not write configuration while the checksum runs.
// RQ9 - Continuous mode holds current on, samples inputs 0 to 23 in turn.
// RQ10 - Per-input wetting current selectable: 0, 1, 2, 5, 10, 15 mA.
// RQ11 - Continuous mode waits the startup delay before current and sampling.
// RQ12 - First-cycle sample results are stored as the default switch state.
// RQ13 - First cycle always interrupts; later cycles only on change.
// RQ14 - Reading interrupt status clears it and releases the interrupt pin.
// RQ15 - 0 mA inputs get no current but are still monitored.
// RQ16 - Polling starts when the main trigger bit is set.
// RQ17 - Polling pulses current one input at a time, 0 to 23.
// RQ18 - Polling on-time per input is 64 us to 2048 us.
// RQ19 - Polling samples each input when its on-time ends.
// RQ20 - Polling repeats with a period from 2 ms to 4096 ms.
// RQ21 - Changes that revert between samples cause nothing.
// RQ22 - Polling change interrupts only for inputs with interrupt enabled.
// RQ23 - Checksum feeds registers ascending, MSB first, one bit per clock.
module sssc_scan_seq #(
    parameter int ON_BASE_CYCLES = sssc_pkg::ON_BASE_CYC,
    parameter int PERIOD_BASE_CYCLES = sssc_pkg::PERIOD_BASE_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Scan configuration
    input wire logic scan_trigger,
    input wire logic poll_mode,
    input wire logic [2:0] poll_on_time_field,
    input wire logic [3:0] poll_period_field,
    input wire logic [sssc_pkg::NUM_IN-1:0] input_enable,
    input wire logic [35:0] wetting_current_config0,
    input wire logic [35:0] wetting_current_config1,
    input wire logic [sssc_pkg::NUM_IN-1:0] switch_irq_enable,
    input wire logic checksum_done_irq_enable,
    // Comparator
    input wire logic comp_out,
    output logic [sssc_pkg::IDX_W-1:0] comp_sel,
    output logic comp_sample,
    // Wetting current drive
    output logic [sssc_pkg::NUM_IN-1:0] wet_on,
    output logic [sssc_pkg::NUM_IN-1:0][sssc_pkg::WC_W-1:0] wet_code,
    // Switch and interrupt status
    output logic [sssc_pkg::NUM_IN-1:0] comparator_switch_status,
    output sssc_pkg::sssc_irq_stat_t interrupt_status,
    output logic spi_status_ssc,
    output logic interrupt_request_pin_b,
    input wire logic int_stat_read,
    // Checksum
    input wire logic checksum_trigger_wr,
    input wire sssc_pkg::sssc_cfg_arr_t config_regs,
    output logic checksum_trigger_bit,
    output logic checksum_busy,
    output logic [15:0] checksum_result
);
    import sssc_pkg::*;

    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(NUM_IN - 1);

    // Comparator synchroniser
    logic comp_meta_reg;
    logic comp_sync_reg;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            comp_meta_reg <= 1'b0;
            comp_sync_reg <= 1'b0;
        end else begin
            comp_meta_reg <= comp_out;
            comp_sync_reg <= comp_meta_reg;
        end
    end

    // Scan sequencer
    sssc_state_t state_reg, state_next;
    logic [IDX_W-1:0] idx_reg, idx_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] per_reg, per_next;
    logic first_reg, first_next;
    logic [NUM_IN-1:0] status_reg, status_next;
    logic sample_evt;
    logic ssc_set;
    logic [2:0] on_field;
    logic [3:0] per_field;
    logic [CNT_W-1:0] on_cyc;
    logic [CNT_W-1:0] period_cyc;
    logic [CNT_W-1:0] dwell_cyc;

    // Out-of-range fields saturate so counts never overflow
    always_comb begin
        on_field = (int'(poll_on_time_field) > ON_FIELD_MAX) ?
            3'(ON_FIELD_MAX) : poll_on_time_field;
        per_field = (int'(poll_period_field) > PERIOD_FIELD_MAX) ?
            4'(PERIOD_FIELD_MAX) : poll_period_field;
        on_cyc = CNT_W'(ON_BASE_CYCLES) << on_field; // RQ18
        period_cyc = CNT_W'(PERIOD_BASE_CYCLES) << per_field; // RQ20
        dwell_cyc = poll_mode ? on_cyc : CNT_W'(DWELL_CYC);
    end

    always_comb begin
        state_next = state_reg;
        idx_next = idx_reg;
        cnt_next = cnt_reg;
        per_next = per_reg;
        first_next = first_reg;
        status_next = status_reg;
        sample_evt = 1'b0;
        ssc_set = 1'b0;
        unique case (state_reg)
            S_IDLE: begin
                if (scan_trigger) begin // RQ16
                    first_next = 1'b1;
                    idx_next = '0;
                    cnt_next = '0;
                    per_next = '0;
                    state_next = poll_mode ? S_SCAN : S_START;
                end
            end
            S_START: begin
                if (cnt_reg == CNT_W'(STARTUP_CYC - 1)) begin // RQ11
                    cnt_next = '0;
                    per_next = '0;
                    state_next = S_SCAN;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            S_SCAN: begin
                per_next = per_reg + 1'b1;
                // Disabled inputs are skipped in a single cycle
                if (!input_enable[idx_reg] ||
                    cnt_reg >= dwell_cyc - 1'b1) begin
                    if (input_enable[idx_reg]) begin
                        sample_evt = 1'b1; // RQ19
                        if (first_reg) begin
                            status_next[idx_reg] = comp_sync_reg; // RQ12
                        end else if (comp_sync_reg != status_reg[idx_reg]) begin
                            status_next[idx_reg] = comp_sync_reg; // RQ21
                            ssc_set = switch_irq_enable[idx_reg]; // RQ22
                        end
                    end
                    cnt_next = '0;
                    if (idx_reg == LAST_IDX) begin
                        state_next = S_WAIT;
                        first_next = 1'b0;
                        if (first_reg) begin
                            ssc_set = 1'b1; // RQ13
                        end
                    end else begin
                        idx_next = idx_reg + 1'b1; // RQ9 RQ17
                    end
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            S_WAIT: begin
                // A scan longer than the period restarts at once
                if (per_reg >= period_cyc - 1'b1) begin // RQ20
                    per_next = '0;
                    idx_next = '0;
                    state_next = S_SCAN;
                end else begin
                    per_next = per_reg + 1'b1;
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
        if (!scan_trigger) begin
            state_next = S_IDLE;
            first_next = 1'b1;
            cnt_next = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= S_IDLE;
            idx_reg <= '0;
            cnt_reg <= '0;
            per_reg <= '0;
            first_reg <= 1'b1;
            status_reg <= RST_SWITCH_STATUS;
        end else begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            cnt_reg <= cnt_next;
            per_reg <= per_next;
            first_reg <= first_next;
            status_reg <= status_next;
        end
    end

    // Wetting current per input
    logic [NUM_IN-1:0] zero_ma;
    logic [NUM_IN-1:0] wet_on_next;
    logic [NUM_IN-1:0][WC_W-1:0] code;
    logic [NUM_IN-1:0][WC_W-1:0] wet_code_next;
    logic [NUM_IN-1:0] wet_on_reg;
    logic [NUM_IN-1:0][WC_W-1:0] wet_code_reg;
    logic [IDX_W-1:0] comp_sel_reg;
    logic comp_sample_reg;

    for (genvar gi = 0; gi < NUM_IN; gi++) begin : g_in
        if (gi < NUM_IN / 2) begin : g_lo
            assign code[gi] = wetting_current_config0[WC_W*gi +: WC_W];
        end else begin : g_hi
            assign code[gi] =
                wetting_current_config1[WC_W*(gi-NUM_IN/2) +: WC_W];
        end
        // Unused codes drive nothing
        assign zero_ma[gi] = (code[gi] == WC_0MA) || (code[gi] > WC_15MA);
        assign wet_on_next[gi] = input_enable[gi] && !zero_ma[gi] && // RQ15
            (poll_mode ?
                (state_next == S_SCAN && idx_next == IDX_W'(gi)) : // RQ17
                (state_next == S_SCAN || state_next == S_WAIT)); // RQ9
        assign wet_code_next[gi] = wet_on_next[gi] ? code[gi] : WC_0MA; // RQ10
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wet_on_reg <= '0;
            wet_code_reg <= '0;
            comp_sel_reg <= '0;
            comp_sample_reg <= 1'b0;
        end else begin
            wet_on_reg <= wet_on_next;
            wet_code_reg <= wet_code_next;
            comp_sel_reg <= idx_next;
            comp_sample_reg <= sample_evt;
        end
    end

    // Checksum sequencer
    logic crc_busy_reg, crc_busy_next;
    logic crc_fin_reg, crc_fin_next;
    logic trig_bit_reg, trig_bit_next;
    logic [CFG_IDX_W-1:0] crc_ri_reg, crc_ri_next;
    logic [CFG_BIT_W-1:0] crc_bi_reg, crc_bi_next;
    logic [15:0] result_reg, result_next;
    logic [15:0] crc_value;
    logic [CFG_W-1:0] crc_word;
    logic crc_clear;
    logic crc_shift;
    logic crc_set;

    always_comb begin
        crc_busy_next = crc_busy_reg;
        crc_fin_next = crc_fin_reg;
        trig_bit_next = trig_bit_reg;
        crc_ri_next = crc_ri_reg;
        crc_bi_next = crc_bi_reg;
        result_next = result_reg;
        crc_clear = 1'b0;
        crc_shift = 1'b0;
        crc_set = 1'b0;
        crc_word = config_regs[crc_ri_reg] & CFG_USED_MASK[crc_ri_reg]; // RQ3
        if (crc_ri_reg == '0) begin
            crc_word[CRC_TRIG_POS] = 1'b1; // RQ5
        end
        if (crc_fin_reg) begin
            result_next = crc_value; // RQ6
            trig_bit_next = 1'b0; // RQ4
            crc_busy_next = 1'b0;
            crc_fin_next = 1'b0;
            crc_set = checksum_done_irq_enable; // RQ7
        end else if (crc_busy_reg) begin
            crc_shift = 1'b1; // RQ23
            if (crc_bi_reg == '0) begin
                crc_bi_next = CFG_BIT_W'(CFG_W - 1);
                if (crc_ri_reg == CFG_IDX_W'(NUM_CFG - 1)) begin // RQ2
                    crc_fin_next = 1'b1;
                end else begin
                    crc_ri_next = crc_ri_reg + 1'b1;
                end
            end else begin
                crc_bi_next = crc_bi_reg - 1'b1;
            end
        end else if (checksum_trigger_wr) begin // RQ4
            crc_busy_next = 1'b1;
            trig_bit_next = 1'b1;
            crc_ri_next = '0;
            crc_bi_next = CFG_BIT_W'(CFG_W - 1);
            crc_clear = 1'b1; // RQ1
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            crc_busy_reg <= 1'b0;
            crc_fin_reg <= 1'b0;
            trig_bit_reg <= 1'b0;
            crc_ri_reg <= '0;
            crc_bi_reg <= '0;
            result_reg <= RST_CRC_RESULT;
        end else begin
            crc_busy_reg <= crc_busy_next;
            crc_fin_reg <= crc_fin_next;
            trig_bit_reg <= trig_bit_next;
            crc_ri_reg <= crc_ri_next;
            crc_bi_reg <= crc_bi_next;
            result_reg <= result_next;
        end
    end

    sssc_crc16 u_crc (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .crc_clear(crc_clear),
        .crc_shift(crc_shift),
        .crc_din(crc_word[crc_bi_reg]),
        .crc_value(crc_value)
    );

    // Interrupt status; a set in the read cycle survives the clear
    sssc_irq_stat_t stat_reg, stat_next;
    logic irq_b_reg, irq_b_next;
    logic ssc_flag_reg;

    always_comb begin
        stat_next = int_stat_read ? '0 : stat_reg; // RQ14
        if (ssc_set) begin
            stat_next.switch_change_flag = 1'b1; // RQ13
        end
        if (crc_set) begin
            stat_next.checksum_done_flag = 1'b1; // RQ6
        end
        irq_b_next = !(stat_next.switch_change_flag ||
            stat_next.checksum_done_flag);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_reg <= '0;
            irq_b_reg <= 1'b1;
            ssc_flag_reg <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            irq_b_reg <= irq_b_next;
            ssc_flag_reg <= stat_next.switch_change_flag;
        end
    end

    assign comp_sel = comp_sel_reg;
    assign comp_sample = comp_sample_reg;
    assign wet_on = wet_on_reg;
    assign wet_code = wet_code_reg;
    assign comparator_switch_status = status_reg;
    assign interrupt_status = stat_reg;
    assign spi_status_ssc = ssc_flag_reg;
    assign interrupt_request_pin_b = irq_b_reg;
    assign checksum_trigger_bit = trig_bit_reg;
    assign checksum_busy = crc_busy_reg;
    assign checksum_result = result_reg;

    // Checks
    logic [9:0] crc_len_reg;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            crc_len_reg <= '0;
        end else begin
            crc_len_reg <= crc_busy_reg ? crc_len_reg + 1'b1 : 10'h000;
        end
    end

    sequence s_first_end;
        state_reg == S_SCAN && first_reg && state_next == S_WAIT && scan_trigger;
    endsequence

    sequence s_irq_up;
        stat_reg.switch_change_flag && !irq_b_reg && ssc_flag_reg;
    endsequence

    a_crc_length: assert property ( // RQ2
        @(posedge ref_clk) disable iff (!rst_b)
        $fell(crc_busy_reg) |-> $past(crc_len_reg) == 10'(CRC_CYCLES - 1))
        else $error("checksum run length wrong");

    a_crc_store: assert property ( // RQ4
        @(posedge ref_clk) disable iff (!rst_b)
        crc_fin_reg |=> result_reg == $past(crc_value) && !trig_bit_reg
            && !crc_busy_reg)
        else $error("checksum result or trigger clear missing");

    a_crc_irq: assert property ( // RQ6
        @(posedge ref_clk) disable iff (!rst_b)
        crc_fin_reg && checksum_done_irq_enable |=>
            stat_reg.checksum_done_flag && !irq_b_reg)
        else $error("checksum done interrupt missing");

    a_crc_masked: assert property ( // RQ7
        @(posedge ref_clk) disable iff (!rst_b)
        crc_fin_reg && !checksum_done_irq_enable &&
            !stat_reg.checksum_done_flag |=> !stat_reg.checksum_done_flag)
        else $error("masked checksum interrupt raised");

    a_read_clears: assert property ( // RQ14
        @(posedge ref_clk) disable iff (!rst_b)
        int_stat_read && !ssc_set && !crc_set |=> stat_reg == '0 && irq_b_reg)
        else $error("status read did not clear");

    a_first_irq: assert property ( // RQ13
        @(posedge ref_clk) disable iff (!rst_b)
        s_first_end |=> s_irq_up)
        else $error("first cycle interrupt missing");

    a_poll_single: assert property ( // RQ17
        @(posedge ref_clk) disable iff (!rst_b)
        poll_mode && $past(poll_mode) |-> $onehot0(wet_on_reg))
        else $error("more than one polled current on");

    a_zero_ma_off: assert property ( // RQ15
        @(posedge ref_clk) disable iff (!rst_b)
        (wet_on_reg & $past(zero_ma)) == '0)
        else $error("current on for 0 mA input");

    a_startup_dark: assert property ( // RQ11
        @(posedge ref_clk) disable iff (!rst_b)
        state_reg == S_START |-> wet_on_reg == '0 && !comp_sample_reg)
        else $error("current or sampling during startup");

    a_status_cause: assert property ( // RQ21
        @(posedge ref_clk) disable iff (!rst_b)
        status_reg != $past(status_reg) |-> comp_sample_reg)
        else $error("switch status changed without sample");

endmodule

//--- verif/sssc_switch_model.sv
`timescale 1ns/100ps
module sssc_switch_model (
    // Selection from the sequencer
    comp_sel,
    // Switch levels set by the bench
    switch_level,
    // Comparator result
    comp_out
);
    import sssc_pkg::*;
    input wire logic [IDX_W-1:0] comp_sel;
    input wire logic [NUM_IN-1:0] switch_level;
    output logic comp_out;

    // Unused indices read as open so a stray select never looks closed
    always_comb begin
        comp_out = (comp_sel < NUM_IN) ? switch_level[comp_sel] : 1'b0;
    end
endmodule

//--- verif/sssc_scan_seq_test.sv
`timescale 1ns/100ps
module sssc_scan_seq_test;
    import sssc_pkg::*;
    localparam int ON_B = 8;
    localparam int PER_B = 400;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic trig = 1'b0;
    logic poll = 1'b0;
    logic [2:0] on_fld = 3'h0;
    logic [3:0] per_fld = 4'h0;
    logic [NUM_IN-1:0] in_en = 24'h000000;
    logic [35:0] wc0 = 36'h000000000;
    logic [35:0] wc1 = 36'h000000000;
    logic [NUM_IN-1:0] irq_en = 24'h000000;
    logic crc_ie = 1'b0;
    logic int_rd = 1'b0;
    logic crc_wr = 1'b0;
    sssc_cfg_arr_t cfg = '0;
    logic [NUM_IN-1:0] sw_level = 24'h000000;
    logic comp_out;
    logic [IDX_W-1:0] comp_sel;
    logic [NUM_IN-1:0] wet_on;
    logic [NUM_IN-1:0][WC_W-1:0] wet_code;
    logic [NUM_IN-1:0] sw_stat;
    sssc_irq_stat_t ist;
    logic ssc_copy;
    logic irq_b;
    logic crc_bit;
    logic crc_busy;
    logic [15:0] crc_res;
    logic [NUM_IN-1:0] wet_prev = 24'h000000;
    logic [71:0] exp_code;
    logic [23:0] pat [4] = '{24'h000000, 24'hffffff, 24'h5a3c81, 24'h000002};
    int run = 0;
    int n;
    int mismatches = 0;
    int n_tests = 0;
    logic samp;
    int n_samp = 0;
    int t_cyc = 0;
    int t_start = -1;

    always #12.5 ref_clk = ~ref_clk;

    sssc_switch_model i_sssc_switch_model (.comp_sel(comp_sel),
        .switch_level(sw_level), .comp_out(comp_out));

    sssc_scan_seq #(.ON_BASE_CYCLES(ON_B), .PERIOD_BASE_CYCLES(PER_B))
    i_sssc_scan_seq (.ref_clk(ref_clk), .rst_b(rst_b),
        .scan_trigger(trig), .poll_mode(poll),
        .poll_on_time_field(on_fld), .poll_period_field(per_fld),
        .input_enable(in_en), .wetting_current_config0(wc0),
        .wetting_current_config1(wc1), .switch_irq_enable(irq_en),
        .checksum_done_irq_enable(crc_ie), .comp_out(comp_out),
        .comp_sel(comp_sel), .comp_sample(samp), .wet_on(wet_on),
        .wet_code(wet_code), .comparator_switch_status(sw_stat),
        .interrupt_status(ist), .spi_status_ssc(ssc_copy),
        .interrupt_request_pin_b(irq_b), .int_stat_read(int_rd),
        .checksum_trigger_wr(crc_wr), .config_regs(cfg),
        .checksum_trigger_bit(crc_bit), .checksum_busy(crc_busy),
        .checksum_result(crc_res));

    task automatic chk(input string nm, input logic [71:0] e,
                       input logic [71:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        if (mismatches == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic logic [15:0] crc_of(input sssc_cfg_arr_t c);
        logic [15:0] r;
        logic b;
        r = 16'hffff;
        c = c & CFG_USED_MASK;
        c[0][CRC_TRIG_POS] = 1'b1;
        for (int i = 0; i < NUM_CFG; i++) begin
            for (int j = CFG_W - 1; j >= 0; j--) begin
                b = r[15] ^ c[i][j];
                r = {r[14:0], 1'b0} ^ (b ? 16'h1021 : 16'h0000);
            end
        end
        return r;
    endfunction

    task automatic read_clr();
        int_rd = 1'b1;
        @(negedge ref_clk);
        int_rd = 1'b0;
        chk("irq_flags", 2'b00, ist);
        chk("irq_pin_b", 1'b1, irq_b);
    endtask

    task automatic wait_ssc(input int lim);
        n = 0;
        while (ist.switch_change_flag !== 1'b1 && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    // Each polled input must stay on exactly its programmed time
    always @(negedge ref_clk) begin
        t_cyc++;
        if (samp === 1'b1)
            n_samp++;
        if (trig !== 1'b1)
            t_start = -1;
        // Scan starts must follow the programmed period
        if (poll && trig && wet_on[0] && !wet_prev[0]) begin
            if (t_start >= 0)
                chk("period", PER_B << per_fld, t_cyc - t_start);
            t_start = t_cyc;
        end
        if (poll && trig && wet_prev != 0 && wet_on !== wet_prev)
            chk("on_time", ON_B << on_fld, run);
        if (poll && trig)
            chk("one_on", 1'b1, $onehot0(wet_on));
        run = (wet_on === wet_prev) ? run + 1 : 1;
        wet_prev = wet_on;
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        mismatches++;
        complete_run();
    end

    initial begin
        repeat (16) @(negedge ref_clk);
        rst_b = 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(negedge ref_clk);
            cfg = {NUM_CFG{pat[k]}};
            crc_ie = k[0];
            crc_wr = 1'b1;
            @(negedge ref_clk);
            crc_wr = 1'b0;
            chk("crc_bit_set", 1'b1, crc_bit);
            n = 0;
            // Configuration held still until the engine finishes
            while (crc_busy === 1'b1 && n < 400) begin
                @(negedge ref_clk);
                n++;
            end
            chk("crc_cycles", 265, n);
            chk("crc_result", crc_of(cfg), crc_res);
            chk("crc_bit_clr", 1'b0, crc_bit);
            chk("crc_flag", crc_ie, ist.checksum_done_flag);
            chk("crc_pin_b", !crc_ie, irq_b);
            read_clr();
        end
        // Polling: first cycle, ignored glitch, masked and unmasked change
        in_en = 24'hffffff;
        // Non-zero currents so the polled pulses are visible
        wc0 = {12{3'h2}};
        wc1 = {12{3'h2}};
        irq_en = 24'h000088;
        sw_level = 24'h00f00e;
        poll = 1'b1;
        trig = 1'b1;
        wait_ssc(1000);
        chk("ssc_first", 1'b1, ist.switch_change_flag);
        chk("ssc_copy", 1'b1, ssc_copy);
        chk("pin_first", 1'b0, irq_b);
        chk("status_first", sw_level, sw_stat);
        read_clr();
        on_fld = 3'h1;
        sw_level[7] = 1'b1;
        repeat (100) @(negedge ref_clk);
        sw_level[7] = 1'b0;
        sw_level[5] = 1'b1;
        repeat (1000) @(negedge ref_clk);
        chk("ssc_masked", 1'b0, ist.switch_change_flag);
        chk("status_next", sw_level, sw_stat);
        sw_level[3] = 1'b0;
        wait_ssc(1000);
        chk("ssc_change", 1'b1, ist.switch_change_flag);
        chk("status_chg", sw_level, sw_stat);
        read_clr();
        // Continuous: codes i mod 8, input 0 off, 0 mA inputs monitored
        trig = 1'b0;
        poll = 1'b0;
        in_en = 24'hfffffe;
        exp_code = '0;
        for (int i = 0; i < NUM_IN; i++) begin
            if (i < 12)
                wc0[3*i +: 3] = 3'(i % 8);
            else
                wc1[3*(i-12) +: 3] = 3'(i % 8);
            if (i > 0 && i % 8 > 0 && i % 8 < 6)
                exp_code[3*i +: 3] = 3'(i % 8);
        end
        sw_level = 24'h000140;
        @(negedge ref_clk);
        trig = 1'b1;
        repeat (3990) @(negedge ref_clk);
        chk("startup_off", 24'h000000, wet_on);
        n_samp = 0;
        wait_ssc(2000);
        chk("ssc_cont", 1'b1, ist.switch_change_flag);
        chk("wet_code", exp_code, wet_code);
        for (int i = 0; i < NUM_IN; i++)
            chk("wet_on", exp_code[3*i +: 3] != 0, wet_on[i]);
        chk("status_cont", sw_level, sw_stat);
        @(negedge ref_clk);
        chk("samples", 23, n_samp);
        rst_b = 1'b0;
        @(negedge ref_clk);
        chk("rst_wet", 24'h000000, wet_on);
        chk("rst_stat", 24'h000000, sw_stat);
        chk("rst_pin_b", 1'b1, irq_b);
        chk("rst_crc", 16'h0000, crc_res);
        complete_run();
    end
endmodule
